// *** adcrd_readout.sv ***
/*
 * Serial readout of a successive-approximation converter, 3-wire modes:
 * turbo, without busy indicator, with busy indicator, plus six status bits.
 * Assumes convert_start and sck come from the host asynchronously and are
 * slow against clk; sample_data comes from the converter core on clk.
 */
// Design decisions made here: the strobed register port and the placing of the registers.
// Summary of operation
// - Six status bits follow each result only while status enable is 1.
// - Status bits go out MSB first on the fall after the result LSB.
// - Output releases after the sixth status bit.
// - An unfinished readout never blocks the next conversion start.
// - Status bits: overvoltage, span, high-Z, turbo, then two reserved.
// - Turbo enable 1 selects turbo in place of the busy-indicator mode.
// - Turbo shifts out the previous conversion result.
// - Convert-start rise starts a conversion and releases the output.
// - A started conversion completes regardless of convert-start.
// - Convert-start fall shows the MSB; each later fall shifts a bit.
// - Output releases after fall 20, or 26 with status bits.
// - Turbo and no-busy release at the last fall or convert-start rise.
// - Non-turbo modes need turbo 0; turbo is 0 after reset.
// - Busy mode keeps output released, then drives low at completion.
// - Busy mode: result on falls 1-20, release on extra fall or rise.
// - Span, high-Z and turbo enables are read/write, reset zero.
// - Overvoltage flag is active low, sticky, cleared by a later read.
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_regs.svh"

module adcrd_readout #(
    parameter int CONV_CYC = `ADCRD_CONV_CYC,
    parameter int RES_W = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Host pins
    input wire logic convert_start,
    input wire logic sck,
    output logic sdo_o,
    output logic sdo_oen,
    // Converter core
    input wire logic [RES_W-1:0] sample_data,
    input wire logic ov_event,
    // Status
    output logic converting,
    output logic powered_down
);

    localparam int FW = `ADCRD_FRAME_W;

    // Pin synchronisers and edge history
    logic cnv_s1_q, cnv_s2_q, cnv_s3_q;
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic ov_s1_q, ov_s2_q;
    logic cnv_rise, cnv_fall, sck_fall;

    // Registers
    logic span_q, highz_q, turbo_q, ov_flag_q;
    logic status_en_q, busy_sel_q;
    logic [RES_W-1:0] result_q;

    // Readout
    adcrd_pkg::adcrd_state_t st_q;
    adcrd_pkg::adcrd_mode_t mode;
    logic [FW-1:0] shreg_q;
    logic [4:0] cnt_q;
    logic drv_q;
    logic [4:0] nbits;
    logic t_start, t_busy, t_done;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Frame image: result then status bits; the tail holds the status image even when unused
    function automatic logic [FW-1:0] frame_of(input logic [RES_W-1:0] r,
                                               input logic [5:0] s);
        frame_of = {r, s};
    endfunction

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // Start history resets high: a pin held high through reset
            // must not look like a fresh start; a false fall is ignored
            cnv_s1_q <= 1'b1;
            cnv_s2_q <= 1'b1;
            cnv_s3_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            ov_s1_q <= 1'b0;
            ov_s2_q <= 1'b0;
        end else begin
            cnv_s1_q <= convert_start;
            cnv_s2_q <= cnv_s1_q;
            cnv_s3_q <= cnv_s2_q;
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            ov_s1_q <= ov_event;
            ov_s2_q <= ov_s1_q;
        end
    end

    // Edges seen from the second stage on; the first stage feeds only it
    assign cnv_rise = cnv_s2_q && !cnv_s3_q;
    assign cnv_fall = !cnv_s2_q && cnv_s3_q;
    assign sck_fall = !sck_s2_q && sck_s3_q;

    assign mode = adcrd_pkg::mode_of(turbo_q, busy_sel_q);
    assign nbits = status_en_q ? `ADCRD_FRAME_BITS_STATUS
                               : `ADCRD_RESULT_BITS;

    // Rises during a conversion are ignored by the timer
    assign t_start = cnv_rise;

    adcrd_conv_timer #(
        .CYCLES(CONV_CYC)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .start(t_start),
        .busy(t_busy),
        .done(t_done)
    );

    // Configuration: enables reset to zero, so turbo is off after reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            span_q <= 1'b0;
            highz_q <= 1'b0;
            turbo_q <= 1'b0;
        end else if (reg_wr && reg_addr == `ADCRD_OFS_CFG) begin
            span_q <= reg_wdata[`ADCRD_CFG_SPAN];
            highz_q <= reg_wdata[`ADCRD_CFG_HIGHZ];
            turbo_q <= reg_wdata[`ADCRD_CFG_TURBO];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_en_q <= 1'b0;
            busy_sel_q <= 1'b0;
        end else if (reg_wr && reg_addr == `ADCRD_OFS_MODE) begin
            status_en_q <= reg_wdata[`ADCRD_MODE_STATUS_EN];
            busy_sel_q <= reg_wdata[`ADCRD_MODE_BUSY_SEL];
        end
    end

    // Active-low sticky flag; an ongoing event wins over the clearing read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ov_flag_q <= 1'(`ADCRD_CFG_RST);
        end else if (ov_s2_q) begin
            ov_flag_q <= 1'b0;
        end else if (reg_rd && reg_addr == `ADCRD_OFS_CFG) begin
            ov_flag_q <= 1'b1;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ADCRD_OFS_CFG:
                    reg_rdata <= {28'h0, span_q, highz_q, turbo_q, ov_flag_q};
                `ADCRD_OFS_MODE:
                    reg_rdata <= {30'h0, busy_sel_q, status_en_q};
                `ADCRD_OFS_STATE:
                    reg_rdata <= {22'h0, cnt_q, 2'(mode), drv_q,
                                  st_q == adcrd_pkg::ST_READY, t_busy};
                `ADCRD_OFS_RESULT:
                    reg_rdata <= {{(32-RES_W){1'b0}}, result_q};
                default:
                    reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Last finished result, kept for turbo readout
    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_q <= '0;
        end else if (t_done) begin
            result_q <= sample_data;
        end
    end

    // Conversion sequencing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= adcrd_pkg::ST_ACQ;
        end else begin
            unique case (st_q)
                adcrd_pkg::ST_ACQ,
                adcrd_pkg::ST_READY: begin
                    if (t_start) begin
                        st_q <= adcrd_pkg::ST_CONV;
                    end else if (st_q == adcrd_pkg::ST_READY && drv_q) begin
                        st_q <= adcrd_pkg::ST_ACQ;
                    end
                end
                adcrd_pkg::ST_CONV: begin
                    if (t_done) begin
                        st_q <= (mode == adcrd_pkg::MODE_TURBO)
                                ? adcrd_pkg::ST_ACQ
                                : adcrd_pkg::ST_READY;
                    end
                end
            endcase
        end
    end

    // Serial output; status image taken from the live configuration
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shreg_q <= '0;
            cnt_q <= 5'h0;
            drv_q <= 1'b0;
            sdo_o <= 1'b0;
            sdo_oen <= 1'b1;
        end else if (cnv_rise) begin
            drv_q <= 1'b0;
            sdo_oen <= 1'b1;
            if (mode == adcrd_pkg::MODE_TURBO) begin
                shreg_q <= frame_of(result_q, {ov_flag_q, span_q, highz_q,
                                    turbo_q, 2'b00});
            end
        end else if (t_done && mode != adcrd_pkg::MODE_TURBO) begin
            shreg_q <= frame_of(sample_data, {ov_flag_q, span_q, highz_q,
                                turbo_q, 2'b00});
            if (mode == adcrd_pkg::MODE_BUSY) begin
                drv_q <= 1'b1;
                sdo_oen <= 1'b0;
                sdo_o <= 1'b0;
                cnt_q <= 5'h0;
            end
        end else if (cnv_fall && mode != adcrd_pkg::MODE_BUSY &&
                     (mode == adcrd_pkg::MODE_TURBO ||
                      st_q == adcrd_pkg::ST_READY)) begin
            drv_q <= 1'b1;
            sdo_oen <= 1'b0;
            sdo_o <= shreg_q[FW-1];
            shreg_q <= {shreg_q[FW-2:0], 1'b0};
            cnt_q <= 5'h1;
        end else if (sck_fall && drv_q) begin
            if (cnt_q == nbits) begin
                drv_q <= 1'b0;
                sdo_oen <= 1'b1;
            end else begin
                sdo_o <= shreg_q[FW-1];
                shreg_q <= {shreg_q[FW-2:0], 1'b0};
                cnt_q <= cnt_q + 5'h1;
            end
        end
    end

    // Status outputs, one cycle behind the timer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            converting <= 1'b0;
            powered_down <= 1'b1;
        end else begin
            converting <= t_busy;
            powered_down <= !t_busy;
        end
    end

    sequence s_read_open;
        cnv_fall && mode == adcrd_pkg::MODE_NOBUSY &&
        st_q == adcrd_pkg::ST_READY;
    endsequence

    sequence s_last_fall;
        sck_fall && drv_q && cnt_q == nbits && !cnv_rise;
    endsequence

    AST_RISE_RELEASE: assert property (cnv_rise |=> sdo_oen && !drv_q)
        else $error("output not released on convert-start rise");

    AST_CONV_RUNS: assert property (t_busy && cnv_rise && !t_done
                                    |=> t_busy || t_done)
        else $error("conversion aborted by convert-start");

    AST_MSB_OUT: assert property (s_read_open
                                  |=> !sdo_oen && sdo_o == $past(shreg_q[25])
                                  && cnt_q == 5'h1)
        else $error("MSB not presented on convert-start fall");

    AST_FRAME_END: assert property (s_last_fall |=> sdo_oen)
        else $error("output not released after last falling edge");

    AST_NO_STATUS: assert property (!status_en_q && drv_q && sck_fall
                                    && cnt_q == 5'h14 && !cnv_rise
                                    |=> sdo_oen)
        else $error("output driven past result without status enable");

    AST_TURBO_PREV: assert property (cnv_rise && turbo_q
                                     |=> shreg_q[25:6] == $past(result_q))
        else $error("turbo frame not loaded from previous result");

    AST_BUSY_LOW: assert property (t_done && mode == adcrd_pkg::MODE_BUSY
                                   && !cnv_rise
                                   |=> !sdo_oen && !sdo_o ##1 !sdo_o)
        else $error("busy mode completion not driven low");

    AST_BUSY_HIZ: assert property (t_busy && mode == adcrd_pkg::MODE_BUSY
                                   |-> sdo_oen)
        else $error("output driven during busy-mode conversion");

    AST_RSV_ZERO: assert property (t_done && !turbo_q && !cnv_rise
                                   |=> shreg_q[1:0] == 2'b00)
        else $error("reserved status bits not zero");

    AST_OV_STICKY: assert property (ov_s2_q ##1 !ov_s2_q && !reg_rd
                                    |=> !ov_flag_q)
        else $error("overvoltage flag cleared without a read");

    AST_TURBO_RESET: assert property ($rose(rstn) |-> !turbo_q)
        else $error("turbo enabled after reset");

endmodule // adcrd_readout

`default_nettype wire

// *** adcrd_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter serial readout block.
 * Assumes a 50 MHz system clock and a byte-addressed register port.
 */
`ifndef ADCRD_REGS_SVH
`define ADCRD_REGS_SVH

// Register byte offsets
`define ADCRD_OFS_CFG 8'h00
`define ADCRD_OFS_MODE 8'h04
`define ADCRD_OFS_STATE 8'h08
`define ADCRD_OFS_RESULT 8'h0c

// Configuration register fields
`define ADCRD_CFG_SPAN 3
`define ADCRD_CFG_HIGHZ 2
`define ADCRD_CFG_TURBO 1
`define ADCRD_CFG_OVFLAG 0
`define ADCRD_CFG_RST 4'h1

// Mode register fields
`define ADCRD_MODE_STATUS_EN 0
`define ADCRD_MODE_BUSY_SEL 1

// Frame lengths in serial-clock falling edges
`define ADCRD_RESULT_BITS 5'h14
`define ADCRD_FRAME_BITS_STATUS 5'h1a
`define ADCRD_FRAME_W 26

// Timing: conversion time in ns, clock rate in MHz
`define ADCRD_CLK_MHZ 50
`define ADCRD_CONV_TIME_NS 500
`define ADCRD_CONV_CYC \
    ((`ADCRD_CONV_TIME_NS * `ADCRD_CLK_MHZ + 999) / 1000)

`endif

// *** adcrd_pkg.sv ***
/*
 * Types shared by the converter serial readout block.
 * Assumes the constants of adcrd_regs.svh are in scope where needed.
 */
package adcrd_pkg;

    typedef enum logic [1:0] {
        MODE_TURBO,
        MODE_NOBUSY,
        MODE_BUSY
    } adcrd_mode_t;

    typedef enum logic [1:0] {
        ST_ACQ,
        ST_CONV,
        ST_READY
    } adcrd_state_t;

    // Turbo overrides the busy indicator selection
    function automatic adcrd_mode_t mode_of(input logic turbo,
                                            input logic busy_sel);
        if (turbo) begin
            return MODE_TURBO;
        end
        return busy_sel ? MODE_BUSY : MODE_NOBUSY;
    endfunction

endpackage

// *** adcrd_conv_timer.sv ***
/*
 * Conversion timer: counts the conversion time from a start pulse and
 * gives a one-cycle done pulse at its end.
 * Assumes start comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adcrd_conv_timer #(
    parameter int CYCLES = 25
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    // A start while busy is ignored: a conversion always completes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            cnt_q <= '0;
        end else if (!busy) begin
            busy <= start;
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            busy <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= busy && (cnt_q == LAST);
        end
    end

endmodule // adcrd_conv_timer

`default_nettype wire

// *** adcrd_host.sv ***
/* Host model: drives convert_start and sck, samples the sdo wire.
   Assumes a 50 MHz clk and a pull-up on the sdo line. */
`timescale 1ns/1ps
`default_nettype none

module adcrd_host (
    // Clock
    input wire logic clk,
    // Link
    output logic convert_start,
    output logic sck,
    input wire logic sdo
);
    // Sck stands low outside frames and, except in turbo mode, during conversions; the serial
    // input is tied high in all three modes, so it is not modelled
    initial begin
        convert_start = 1'h0;
        sck = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Quiet gap after the last fall before the next start
    task automatic rise();
        tick(4);
        convert_start <= 1'h1;
    endtask

    task automatic fall();
        @(posedge clk);
        convert_start <= 1'h0;
    endtask

    // One 160 ns sck period, ending low
    task automatic pulse();
        @(posedge clk);
        sck <= 1'h1;
        tick(4);
        sck <= 1'h0;
        tick(4);
    endtask

    // Sample n bits MSB first, one fall after each sample
    task automatic frame(input int n, output logic [25:0] bits);
        bits = 26'h0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            bits[25-i] = sdo;
            pulse();
        end
    endtask
endmodule // adcrd_host
`default_nettype wire

// *** adcrd_readout_test.sv ***
/* Self-checking bench of adcrd_readout: registers, three 3-wire
   modes, status bits, overvoltage flag, aborted frame.
   Assumes the adcrd_host model and a pull-up on sdo. */
`timescale 1ns/1ps
`default_nettype none
`include "adcrd_regs.svh"
`define CHK(g, e) chk((g) === (e), `__LINE__)

module adcrd_readout_test;
    // Short conversion keeps the run brief
    localparam int CONV = 12;
    typedef struct packed {
        logic turbo, busy, sten, span, highz, ov;
        logic [19:0] data;
    } adcrd_row_t;
    adcrd_row_t rows [7] = '{
        '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 20'ha5c31},
        '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 20'h5a3ce},
        '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 20'hf0f0f},
        '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 20'h80001},
        '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 20'h12345},
        '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 20'h0fedc},
        '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 20'h6b1d4}
    };
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic convert_start, sck, sdo_o, sdo_oen, sdo;
    logic converting, powered_down;
    logic [19:0] sample_data = 20'h0;
    logic ov_event = 1'h0;
    int failures = 0;
    int n_checks = 0;

    always #10 clk = ~clk;
    // Pull-up holds the released line high
    assign sdo = sdo_oen ? 1'h1 : sdo_o;

    adcrd_readout #(.CONV_CYC(CONV), .RES_W(20)) dut (
        .clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .convert_start(convert_start), .sck(sck),
        .sdo_o(sdo_o), .sdo_oen(sdo_oen),
        .sample_data(sample_data), .ov_event(ov_event),
        .converting(converting), .powered_down(powered_down)
    );
    adcrd_host host (
        .clk(clk), .convert_start(convert_start), .sck(sck), .sdo(sdo)
    );

    task automatic chk(input logic ok, input int ln);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED t=%0t line %0d", $time, ln);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Bounded wait for the end of a conversion
    task automatic wait_conv();
        int k;
        k = 0;
        while (converting !== 1'h0) begin
            @(negedge clk);
            k++;
            if (k > 100) begin
                failures++;
                end_sim();
            end
        end
        `CHK(powered_down, 1'h1);
    endtask

    initial begin
        logic [31:0] d;
        logic [25:0] got, exp;
        logic [19:0] prev;
        adcrd_row_t w;
        int n;
        prev = 20'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        `CHK(sdo_oen, 1'h1);
        `CHK(powered_down, 1'h1);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d, 32'h1);
        wr(`ADCRD_OFS_CFG, 32'hf);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d, 32'hf);
        wr(`ADCRD_OFS_CFG, 32'h0);
        wr(8'h10, 32'hffffffff);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d, 32'h1);
        rd(8'h10, d);
        `CHK(d, 32'h0);
        for (int r = 0; r < 7; r++) begin
            w = rows[r];
            if (!w.ov) begin
                @(posedge clk);
                ov_event <= 1'h1;
                idle(6);
                @(posedge clk);
                ov_event <= 1'h0;
                idle(6);
            end
            wr(`ADCRD_OFS_CFG, {28'h0, w.span, w.highz, w.turbo, 1'h0});
            wr(`ADCRD_OFS_MODE, {30'h0, w.busy, w.sten});
            sample_data <= w.data;
            n = w.sten ? 26 : 20;
            exp = {w.turbo ? prev : w.data, 6'h0};
            if (w.sten) begin
                exp[5:0] = {w.ov, w.span, w.highz, w.turbo, 2'h0};
            end
            host.rise();
            host.tick(2);
            host.fall();
            if (!w.turbo && !w.busy) begin
                host.rise();
            end
            // A pin edge is seen three clocks late
            idle(3);
            `CHK(converting, 1'h1);
            `CHK(powered_down, 1'h0);
            if (!w.turbo) `CHK(sdo_oen, 1'h1);
            if (w.turbo) begin
                host.frame(n, got);
                wait_conv();
            end else begin
                wait_conv();
                if (w.busy) begin
                    idle(2);
                    `CHK(sdo, 1'h0);
                    host.pulse();
                end else begin
                    host.fall();
                    idle(5);
                end
                host.frame(n, got);
            end
            idle(5);
            `CHK(got, exp);
            `CHK(sdo_oen, 1'h1);
            rd(`ADCRD_OFS_RESULT, d);
            `CHK(d, {12'h0, w.data});
            rd(`ADCRD_OFS_STATE, d);
            `CHK(d[4:3], w.turbo ? 2'h0 : (w.busy ? 2'h2 : 2'h1));
            prev = w.data;
        end
        // Flag stays low after the event until a read clears it
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d[0], 1'h0);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d[0], 1'h1);
        @(posedge clk);
        ov_event <= 1'h1;
        idle(6);
        rd(`ADCRD_OFS_CFG, d);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d[0], 1'h0);
        @(posedge clk);
        ov_event <= 1'h0;
        idle(6);
        rd(`ADCRD_OFS_CFG, d);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d[0], 1'h1);
        // Partial frame cut short by the next start
        sample_data <= 20'h3c3c3;
        host.rise();
        idle(6);
        wait_conv();
        host.fall();
        idle(5);
        host.frame(5, got);
        `CHK(got[25:21], 5'h07);
        sample_data <= 20'h9e2b7;
        host.rise();
        idle(5);
        `CHK(sdo_oen, 1'h1);
        `CHK(converting, 1'h1);
        wait_conv();
        rd(`ADCRD_OFS_RESULT, d);
        `CHK(d, 32'h9e2b7);
        // Mid-run reset with turbo on and convert-start still high
        wr(`ADCRD_OFS_CFG, 32'h2);
        @(posedge clk);
        rstn <= 1'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        `CHK(sdo_oen, 1'h1);
        rd(`ADCRD_OFS_CFG, d);
        `CHK(d, 32'h1);
        idle(4);
        `CHK(converting, 1'h0);
        end_sim();
    end
endmodule // adcrd_readout_test
`default_nettype wire
